/* File: rtl/fsk_pkg.sv */
package fsk_pkg;

  // =====================================================================
  // widths
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned COEF_W  = 16;
  localparam int unsigned IDX_W   = 8;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned SEL_W   = 3;
  localparam int unsigned NCOEF   = 6;

  // =====================================================================
  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_REFRESH_CTRL = 8'h20;
  localparam logic [IDX_W-1:0] IDX_SPACE_AMP    = 8'h63;
  localparam logic [IDX_W-1:0] IDX_SPACE_FREQ   = 8'h64;
  localparam logic [IDX_W-1:0] IDX_MARK_AMP     = 8'h65;
  localparam logic [IDX_W-1:0] IDX_MARK_FREQ    = 8'h66;
  localparam logic [IDX_W-1:0] IDX_S2M_GAIN     = 8'h67;
  localparam logic [IDX_W-1:0] IDX_M2S_GAIN     = 8'h68;
  localparam logic [IDX_W-1:0] IDX_KEYING_CTRL  = 8'h6C;
  localparam logic [IDX_W-1:0] IDX_TIMER_CTRL   = 8'h70;
  localparam logic [IDX_W-1:0] IDX_NEXT_SYMBOL  = 8'h71;
  localparam logic [IDX_W-1:0] IDX_TONE1_AMP    = 8'h72;
  localparam logic [IDX_W-1:0] IDX_TONE1_FREQ   = 8'h73;
  localparam logic [IDX_W-1:0] IDX_TIMER_PERIOD = 8'h74;
  localparam logic [IDX_W-1:0] IDX_STATUS       = 8'h75;

  // slots inside the coefficient bank
  localparam logic [SEL_W-1:0] SLOT_SPACE_AMP  = 3'd0;
  localparam logic [SEL_W-1:0] SLOT_SPACE_FREQ = 3'd1;
  localparam logic [SEL_W-1:0] SLOT_MARK_AMP   = 3'd2;
  localparam logic [SEL_W-1:0] SLOT_MARK_FREQ  = 3'd3;
  localparam logic [SEL_W-1:0] SLOT_S2M_GAIN   = 3'd4;
  localparam logic [SEL_W-1:0] SLOT_M2S_GAIN   = 3'd5;

  // =====================================================================
  // field positions
  localparam int unsigned KEYING_EN_BIT  = 6;
  localparam int unsigned REFRESH_EN_BIT = 6;
  localparam int unsigned TIMER_RUN_BIT  = 0;
  localparam int unsigned SYMBOL_BIT     = 0;
  localparam int unsigned ST_RUN_BIT     = 0;
  localparam int unsigned ST_ENH_BIT     = 1;
  localparam int unsigned ST_LAST_BIT    = 2;
  localparam int unsigned ST_AMP_LSB     = 16;
  localparam int unsigned GAIN_SHIFT     = 15;

  // =====================================================================
  // reset values
  localparam logic [COEF_W-1:0] COEF_RST   = 16'h0000;
  localparam logic [COEF_W-1:0] PERIOD_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST   = 32'h0000_0000;

  typedef enum logic [1:0] {
    APB_IDLE   = 2'b00,
    APB_ACCESS = 2'b01,
    APB_DONE   = 2'b10
  } fsk_apb_state_t;

endpackage

/* File: rtl/fsk_coef_if.sv */
`timescale 1ns/100ps
interface fsk_coef_if;
  logic                             wrEn;
  logic [fsk_pkg::SEL_W-1:0]        wrSlot;
  logic [fsk_pkg::COEF_W-1:0]       wrData;
  logic [fsk_pkg::SEL_W-1:0]        rdSlot;
  logic [fsk_pkg::COEF_W-1:0]       rdData;
  logic                             nextSymbol;
  logic                             lastSymbol;
  logic [fsk_pkg::COEF_W-1:0]       selAmp;
  logic [fsk_pkg::COEF_W-1:0]       selFreq;
  logic [fsk_pkg::COEF_W-1:0]       selGain;
  logic                             transition;

  modport bank (
    input  wrEn, wrSlot, wrData, rdSlot, nextSymbol, lastSymbol,
    output rdData, selAmp, selFreq, selGain, transition
  );
  modport core (
    output wrEn, wrSlot, wrData, rdSlot, nextSymbol, lastSymbol,
    input  rdData, selAmp, selFreq, selGain, transition
  );
endinterface

/* File: rtl/fsk_coef_bank.sv */
`timescale 1ns/100ps
module fsk_coef_bank (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic ce,
  // coefficient port
  fsk_coef_if.bank  cb
);

  logic [fsk_pkg::COEF_W-1:0] coef_r [fsk_pkg::NCOEF];
  logic [fsk_pkg::COEF_W-1:0] rdData_r;
  logic [fsk_pkg::COEF_W-1:0] selAmp_r;
  logic [fsk_pkg::COEF_W-1:0] selFreq_r;
  logic [fsk_pkg::COEF_W-1:0] selGain_r;
  logic                       transition_r;

  // =====================================================================
  // storage
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < fsk_pkg::NCOEF; i++)
      begin
        coef_r[i] <= fsk_pkg::COEF_RST;
      end
    end
    else if (ce && cb.wrEn)
    begin
      coef_r[cb.wrSlot] <= cb.wrData;
    end
  end

  // =====================================================================
  // registered selection, settles one cycle after the symbol changes
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdData_r     <= fsk_pkg::COEF_RST;
      selAmp_r     <= fsk_pkg::COEF_RST;
      selFreq_r    <= fsk_pkg::COEF_RST;
      selGain_r    <= fsk_pkg::COEF_RST;
      transition_r <= 1'b0;
    end
    else if (ce)
    begin
      rdData_r     <= (cb.rdSlot < fsk_pkg::SEL_W'(fsk_pkg::NCOEF)) ? coef_r[cb.rdSlot]
                                                                : fsk_pkg::COEF_RST;
      selAmp_r     <= cb.nextSymbol ? coef_r[fsk_pkg::SLOT_MARK_AMP]
                                    : coef_r[fsk_pkg::SLOT_SPACE_AMP];
      selFreq_r    <= cb.nextSymbol ? coef_r[fsk_pkg::SLOT_MARK_FREQ]
                                    : coef_r[fsk_pkg::SLOT_SPACE_FREQ];
      selGain_r    <= cb.nextSymbol ? coef_r[fsk_pkg::SLOT_S2M_GAIN]
                                    : coef_r[fsk_pkg::SLOT_M2S_GAIN];
      transition_r <= cb.nextSymbol != cb.lastSymbol;
    end
  end

  assign cb.rdData     = rdData_r;
  assign cb.selAmp     = selAmp_r;
  assign cb.selFreq    = selFreq_r;
  assign cb.selGain    = selGain_r;
  assign cb.transition = transition_r;

endmodule

/* File: rtl/fsk_tone_reload.sv */
// How it works
// - the keyed path is used only while both the keying enable and the refresh enable are one.
// - on timer expiry with a space queued, the space amplitude replaces the tone amplitude.
// - on timer expiry with a space queued, the space frequency replaces the tone frequency.
// - on timer expiry with a mark queued, the mark amplitude replaces the tone amplitude.
// - on timer expiry with a mark queued, the mark frequency replaces the tone frequency.
// - a space-to-mark change scales the loaded amplitude by the space-to-mark gain.
// - a mark-to-space change scales the loaded amplitude by the mark-to-space gain.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
module fsk_tone_reload (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  input  wire logic                         ce,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [fsk_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [fsk_pkg::DATA_W-1:0]   pwdata,
  output logic      [fsk_pkg::DATA_W-1:0]   prdata,
  output logic                              pready,
  output logic                              pslverr,
  // oscillator 1 load
  output logic      [fsk_pkg::COEF_W-1:0]   oscAmplitude,
  output logic      [fsk_pkg::COEF_W-1:0]   oscFrequency,
  output logic                              oscLoad,
  output logic                              enhancedActive
);

  // =====================================================================
  // state
  fsk_pkg::fsk_apb_state_t apbState_r;
  fsk_pkg::fsk_apb_state_t apbState_nxt;

  logic [fsk_pkg::DATA_W-1:0] prdata_r;
  logic                       pready_r;
  logic                       pslverr_r;
  logic                       keyingEn_r;
  logic                       refreshEn_r;
  logic                       timerRun_r;
  logic                       nextSymbol_r;
  logic                       lastSymbol_r;
  logic [fsk_pkg::COEF_W-1:0] tone1Amp_r;
  logic [fsk_pkg::COEF_W-1:0] tone1Freq_r;
  logic [fsk_pkg::COEF_W-1:0] period_r;
  logic [fsk_pkg::COEF_W-1:0] timer_r;
  logic [fsk_pkg::COEF_W-1:0] oscAmp_r;
  logic [fsk_pkg::COEF_W-1:0] oscFreq_r;
  logic                       oscLoad_r;
  logic                       enhanced_r;

  fsk_coef_if coefBus ();

  // =====================================================================
  // gain correction, q1.15 scale
  function automatic logic [fsk_pkg::COEF_W-1:0] applyGain(
    input logic [fsk_pkg::COEF_W-1:0] amp,
    input logic [fsk_pkg::COEF_W-1:0] gain
  );
    logic [2*fsk_pkg::COEF_W-1:0] prod;
    prod      = amp * gain;
    applyGain = prod[fsk_pkg::GAIN_SHIFT +: fsk_pkg::COEF_W];
  endfunction

  // =====================================================================
  // address decode
  wire logic [fsk_pkg::IDX_W-1:0] regIdx    = paddr[fsk_pkg::IDX_W+1:2];
  wire logic                      upperZero = paddr[fsk_pkg::ADDR_W-1:fsk_pkg::IDX_W+2] == '0;
  wire logic                      hitCoef   = upperZero && regIdx >= fsk_pkg::IDX_SPACE_AMP
                                              && regIdx <= fsk_pkg::IDX_M2S_GAIN;
  wire logic [fsk_pkg::IDX_W-1:0] coefOff   = regIdx - fsk_pkg::IDX_SPACE_AMP;
  wire logic                      hitRefresh = upperZero && regIdx == fsk_pkg::IDX_REFRESH_CTRL;
  wire logic                      hitKeying  = upperZero && regIdx == fsk_pkg::IDX_KEYING_CTRL;
  wire logic                      hitTimerC  = upperZero && regIdx == fsk_pkg::IDX_TIMER_CTRL;
  wire logic                      hitSymbol  = upperZero && regIdx == fsk_pkg::IDX_NEXT_SYMBOL;
  wire logic                      hitT1Amp   = upperZero && regIdx == fsk_pkg::IDX_TONE1_AMP;
  wire logic                      hitT1Freq  = upperZero && regIdx == fsk_pkg::IDX_TONE1_FREQ;
  wire logic                      hitPeriod  = upperZero && regIdx == fsk_pkg::IDX_TIMER_PERIOD;
  wire logic                      hitStatus  = upperZero && regIdx == fsk_pkg::IDX_STATUS;
  wire logic                      mapped     = hitCoef || hitRefresh || hitKeying || hitTimerC
                                               || hitSymbol || hitT1Amp || hitT1Freq
                                               || hitPeriod || hitStatus;

  // write commits only at the edge where pready is seen high
  wire logic wrCommit = psel && penable && pwrite && pready_r && !pslverr_r;

  wire logic [fsk_pkg::COEF_W-1:0] wrHalf = pwdata[fsk_pkg::COEF_W-1:0];

  // =====================================================================
  // read mux, bank data already registered from the setup cycle
  logic [fsk_pkg::DATA_W-1:0] readMux;
  always_comb
  begin
    readMux = fsk_pkg::DATA_RST;
    if (hitCoef)
    begin
      readMux[fsk_pkg::COEF_W-1:0] = coefBus.rdData;
    end
    else if (hitRefresh)
    begin
      readMux[fsk_pkg::REFRESH_EN_BIT] = refreshEn_r;
    end
    else if (hitKeying)
    begin
      readMux[fsk_pkg::KEYING_EN_BIT] = keyingEn_r;
    end
    else if (hitTimerC)
    begin
      readMux[fsk_pkg::TIMER_RUN_BIT] = timerRun_r;
    end
    else if (hitSymbol)
    begin
      readMux[fsk_pkg::SYMBOL_BIT] = nextSymbol_r;
    end
    else if (hitT1Amp)
    begin
      readMux[fsk_pkg::COEF_W-1:0] = tone1Amp_r;
    end
    else if (hitT1Freq)
    begin
      readMux[fsk_pkg::COEF_W-1:0] = tone1Freq_r;
    end
    else if (hitPeriod)
    begin
      readMux[fsk_pkg::COEF_W-1:0] = period_r;
    end
    else if (hitStatus)
    begin
      readMux[fsk_pkg::ST_RUN_BIT]  = timerRun_r;
      readMux[fsk_pkg::ST_ENH_BIT]  = enhanced_r;
      readMux[fsk_pkg::ST_LAST_BIT] = lastSymbol_r;
      readMux[fsk_pkg::ST_AMP_LSB +: fsk_pkg::COEF_W] = oscAmp_r;
    end
  end

  // =====================================================================
  // apb handshake: one wait state on every access
  always_comb
  begin
    case (apbState_r)
      fsk_pkg::APB_IDLE:
      begin
        apbState_nxt = (psel && !penable) ? fsk_pkg::APB_ACCESS : fsk_pkg::APB_IDLE;
      end
      fsk_pkg::APB_ACCESS:
      begin
        apbState_nxt = (psel && penable) ? fsk_pkg::APB_DONE : fsk_pkg::APB_IDLE;
      end
      // back to back: the next setup may follow the answer at once
      fsk_pkg::APB_DONE:
      begin
        apbState_nxt = (psel && !penable) ? fsk_pkg::APB_ACCESS : fsk_pkg::APB_IDLE;
      end
      default:
      begin
        apbState_nxt = fsk_pkg::APB_IDLE;
      end
    endcase
  end

  wire logic answerNow = apbState_r == fsk_pkg::APB_ACCESS && psel && penable;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      apbState_r <= fsk_pkg::APB_IDLE;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      prdata_r   <= fsk_pkg::DATA_RST;
    end
    else if (ce)
    begin
      apbState_r <= apbState_nxt;
      pready_r   <= answerNow;
      pslverr_r  <= answerNow && !mapped;
      if (answerNow)
      begin
        prdata_r <= pwrite ? fsk_pkg::DATA_RST : readMux;
      end
    end
  end

  // =====================================================================
  // control registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      keyingEn_r   <= 1'b0;
      refreshEn_r  <= 1'b0;
      timerRun_r   <= 1'b0;
      nextSymbol_r <= 1'b0;
      tone1Amp_r   <= fsk_pkg::COEF_RST;
      tone1Freq_r  <= fsk_pkg::COEF_RST;
      period_r     <= fsk_pkg::PERIOD_RST;
    end
    else if (ce && wrCommit)
    begin
      if (hitKeying)
      begin
        keyingEn_r <= pwdata[fsk_pkg::KEYING_EN_BIT];
      end
      if (hitRefresh)
      begin
        refreshEn_r <= pwdata[fsk_pkg::REFRESH_EN_BIT];
      end
      if (hitTimerC)
      begin
        timerRun_r <= pwdata[fsk_pkg::TIMER_RUN_BIT];
      end
      if (hitSymbol)
      begin
        nextSymbol_r <= pwdata[fsk_pkg::SYMBOL_BIT];
      end
      if (hitT1Amp)
      begin
        tone1Amp_r <= wrHalf;
      end
      if (hitT1Freq)
      begin
        tone1Freq_r <= wrHalf;
      end
      if (hitPeriod)
      begin
        period_r <= wrHalf;
      end
    end
  end

  // =====================================================================
  // coefficient bank
  assign coefBus.wrEn       = wrCommit && hitCoef;
  assign coefBus.wrSlot     = coefOff[fsk_pkg::SEL_W-1:0];
  assign coefBus.wrData     = wrHalf;
  assign coefBus.rdSlot     = hitCoef ? coefOff[fsk_pkg::SEL_W-1:0] : fsk_pkg::SLOT_SPACE_AMP;
  assign coefBus.nextSymbol = nextSymbol_r;
  assign coefBus.lastSymbol = lastSymbol_r;

  fsk_coef_bank u_bank (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .cb      (coefBus.bank)
  );

  // =====================================================================
  // active timer: period plus one ce cycles between loads
  wire logic timerExpire = timerRun_r && timer_r == '0;

  wire logic enhancedMode = keyingEn_r && refreshEn_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      timer_r <= fsk_pkg::PERIOD_RST;
    end
    else if (ce)
    begin
      if (!timerRun_r || timerExpire)
      begin
        timer_r <= period_r;
      end
      else
      begin
        timer_r <= timer_r - 1'b1;
      end
    end
  end

  // =====================================================================
  // oscillator 1 load
  wire logic [fsk_pkg::COEF_W-1:0] keyedAmp =
    coefBus.transition ? applyGain(coefBus.selAmp, coefBus.selGain) : coefBus.selAmp;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      oscAmp_r     <= fsk_pkg::COEF_RST;
      oscFreq_r    <= fsk_pkg::COEF_RST;
      oscLoad_r    <= 1'b0;
      enhanced_r   <= 1'b0;
      lastSymbol_r <= 1'b0;
    end
    else if (ce)
    begin
      oscLoad_r  <= timerExpire;
      enhanced_r <= enhancedMode;
      if (timerExpire && enhancedMode)
      begin
        oscAmp_r     <= keyedAmp;
        oscFreq_r    <= coefBus.selFreq;
        lastSymbol_r <= nextSymbol_r;
      end
      else if (timerExpire)
      begin
        oscAmp_r  <= tone1Amp_r;
        oscFreq_r <= tone1Freq_r;
      end
    end
  end

  // =====================================================================
  // outputs
  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign oscAmplitude   = oscAmp_r;
  assign oscFrequency   = oscFreq_r;
  assign oscLoad        = oscLoad_r;
  assign enhancedActive = enhanced_r;

endmodule

/* File: tb/fsk_reload_asserts.sv */
`timescale 1ns/100ps
module fsk_reload_chk (
  // clock and reset
  input wire logic                       clk,
  input wire logic                       reset_n,
  input wire logic                       ce,
  // apb
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [fsk_pkg::ADDR_W-1:0] paddr,
  input wire logic [fsk_pkg::DATA_W-1:0] pwdata,
  input wire logic                       pready,
  // oscillator
  input wire logic [fsk_pkg::COEF_W-1:0] oscAmplitude,
  input wire logic [fsk_pkg::COEF_W-1:0] oscFrequency,
  input wire logic                       oscLoad,
  input wire logic                       enhancedActive
);
  // ========
  // shadow of the written registers
  logic [7:0]  idx;
  logic [2:0]  slot;
  logic        wr;
  logic        inBank;
  logic [15:0] cf_r [0:5];
  logic        keyEn_r, refEn_r, sym_r, last_r;
  logic [15:0] s2mAmp, m2sAmp;
  assign idx    = paddr[9:2];
  assign slot   = 3'(idx - fsk_pkg::IDX_SPACE_AMP);
  assign wr     = psel && penable && pwrite && pready && ce && (paddr[11:10] == 2'b00);
  assign inBank = idx >= fsk_pkg::IDX_SPACE_AMP && idx <= fsk_pkg::IDX_M2S_GAIN;
  // gain is q1.15, truncated like the oscillator does
  assign s2mAmp = 16'((32'(cf_r[2]) * 32'(cf_r[4])) >> 15);
  assign m2sAmp = 16'((32'(cf_r[0]) * 32'(cf_r[5])) >> 15);
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      cf_r    <= '{default: 16'h0000};
      keyEn_r <= 1'b0;
      refEn_r <= 1'b0;
      sym_r   <= 1'b0;
      last_r  <= 1'b0;
    end
    else
    begin
      if (wr && inBank)
        cf_r[slot] <= pwdata[15:0];
      if (wr && idx == fsk_pkg::IDX_KEYING_CTRL)
        keyEn_r <= pwdata[fsk_pkg::KEYING_EN_BIT];
      if (wr && idx == fsk_pkg::IDX_REFRESH_CTRL)
        refEn_r <= pwdata[fsk_pkg::REFRESH_EN_BIT];
      if (wr && idx == fsk_pkg::IDX_NEXT_SYMBOL)
        sym_r <= pwdata[fsk_pkg::SYMBOL_BIT];
      if (oscLoad && enhancedActive)
        last_r <= sym_r;
    end

  // ========
  // properties
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_enh;
    $past(ce) |-> enhancedActive == $past(keyEn_r && refEn_r);
  endproperty
  a_enh: assert property (p_enh) else $error("enhanced flag wrong");
  property p_sp_amp;
    oscLoad && enhancedActive && !sym_r && !last_r |-> oscAmplitude == cf_r[0];
  endproperty
  a_sp_amp: assert property (p_sp_amp) else $error("space amplitude wrong");
  property p_sp_freq;
    oscLoad && enhancedActive && !sym_r |-> oscFrequency == cf_r[1];
  endproperty
  a_sp_freq: assert property (p_sp_freq) else $error("space frequency wrong");
  property p_mk_amp;
    oscLoad && enhancedActive && sym_r && last_r |-> oscAmplitude == cf_r[2];
  endproperty
  a_mk_amp: assert property (p_mk_amp) else $error("mark amplitude wrong");
  property p_mk_freq;
    oscLoad && enhancedActive && sym_r |-> oscFrequency == cf_r[3];
  endproperty
  a_mk_freq: assert property (p_mk_freq) else $error("mark frequency wrong");
  property p_s2m;
    oscLoad && enhancedActive && sym_r && !last_r |-> oscAmplitude == s2mAmp;
  endproperty
  a_s2m: assert property (p_s2m) else $error("space to mark gain wrong");
  property p_m2s;
    oscLoad && enhancedActive && !sym_r && last_r |-> oscAmplitude == m2sAmp;
  endproperty
  a_m2s: assert property (p_m2s) else $error("mark to space gain wrong");
  property p_hold;
    !oscLoad |-> $stable(oscAmplitude) && $stable(oscFrequency);
  endproperty
  a_hold: assert property (p_hold) else $error("coefficients moved without load");
  property p_pulse;
    oscLoad && ce |=> !oscLoad [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("load pulse too long");
endmodule

bind fsk_tone_reload fsk_reload_chk u_chk (
  .clk(clk), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .oscAmplitude(oscAmplitude), .oscFrequency(oscFrequency), .oscLoad(oscLoad),
  .enhancedActive(enhancedActive)
);

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb;
  logic                       clk, reset_n, ce, psel, penable, pwrite;
  logic [fsk_pkg::ADDR_W-1:0] paddr;
  logic [31:0]                pwdata, prdata, rd;
  logic                       pready, pslverr, oscLoad, enhancedActive, err;
  logic [15:0]                oscAmplitude, oscFrequency;
  logic [15:0]                cf [0:5];
  int                         num_errors, cmp_count;

  fsk_tone_reload dut (
    .clk(clk), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .oscAmplitude(oscAmplitude),
    .oscFrequency(oscFrequency), .oscLoad(oscLoad), .enhancedActive(enhancedActive)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ========
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tmo;
    num_errors++;
    $display("[ERR] %0t wait timed out", $time);
    finish_test();
  endtask

  // entered and left at a rising edge; pready, prdata and pslverr are
  // read at the rising edge, before the design's updates land
  task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, ix, 2'b00};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (pready !== 1'b1)
      tmo();
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_load;
    int n;
    n = 0;
    @(negedge clk);
    while (oscLoad !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 200)
      tmo();
    @(posedge clk);
  endtask

  function automatic logic [15:0] scl(input logic [15:0] a, input logic [15:0] g);
    logic [31:0] p;
    p = 32'(a) * 32'(g);
    return p[30:15];
  endfunction

  // ========
  // scenarios
  task automatic t_regs;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, 8'h63 + 8'(i), 32'h0000_0000);
      chk(rd, 32'h0000_0000, "coef reset");
      apb(1'b1, 8'h63 + 8'(i), {16'hFFFF, cf[i]});
      apb(1'b0, 8'h63 + 8'(i), 32'h0000_0000);
      chk(rd, {16'h0000, cf[i]}, "coef readback");
    end
    apb(1'b0, 8'h50, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001, "unmapped error");
    chk(rd, 32'h0000_0000, "unmapped data");
    apb(1'b1, 8'h50, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h0000_0001, "unmapped write error");
    // ce low in mid access must only delay the answer
    fork
      apb(1'b0, fsk_pkg::IDX_SPACE_FREQ, 32'h0000_0000);
      begin
        @(posedge clk);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
      end
    join
    chk(rd, {16'h0000, cf[1]}, "stalled read");
    $display("test regs done");
  endtask

  task automatic t_enable;
    logic k, r;
    apb(1'b1, fsk_pkg::IDX_TONE1_AMP, 32'h0000_0AAA);
    apb(1'b1, fsk_pkg::IDX_TONE1_FREQ, 32'h0000_0BBB);
    apb(1'b1, fsk_pkg::IDX_TIMER_PERIOD, 32'h0000_0028);
    for (int c = 0; c < 3; c++)
    begin
      {k, r} = 2'(c);
      apb(1'b1, fsk_pkg::IDX_KEYING_CTRL, 32'(k) << fsk_pkg::KEYING_EN_BIT);
      apb(1'b1, fsk_pkg::IDX_REFRESH_CTRL, 32'(r) << fsk_pkg::REFRESH_EN_BIT);
      apb(1'b1, fsk_pkg::IDX_TIMER_CTRL, 32'h0000_0001);
      wait_load();
      chk({31'h0, enhancedActive}, 32'h0000_0000, "enhanced off");
      chk({16'h0000, oscAmplitude}, 32'h0000_0AAA, "normal amp");
      chk({16'h0000, oscFrequency}, 32'h0000_0BBB, "normal freq");
      apb(1'b1, fsk_pkg::IDX_TIMER_CTRL, 32'h0000_0000);
    end
    $display("test enable done");
  endtask

  task automatic t_seq;
    logic [4:0]  pat;
    logic        s, l;
    logic [15:0] a;
    // symbols in order 0,1,1,0,0: every transition kind
    pat = 5'b00110;
    l   = 1'b0;
    apb(1'b1, fsk_pkg::IDX_KEYING_CTRL, 32'h0000_0040);
    apb(1'b1, fsk_pkg::IDX_REFRESH_CTRL, 32'h0000_0040);
    apb(1'b1, fsk_pkg::IDX_NEXT_SYMBOL, 32'(pat[0]));
    apb(1'b1, fsk_pkg::IDX_TIMER_CTRL, 32'h0000_0001);
    for (int i = 0; i < 5; i++)
    begin
      s = pat[i];
      wait_load();
      a = s ? cf[2] : cf[0];
      if (s != l)
        a = scl(a, s ? cf[4] : cf[5]);
      l = s;
      chk({31'h0, enhancedActive}, 32'h0000_0001, "enhanced on");
      chk({16'h0000, oscAmplitude}, {16'h0000, a}, "keyed amp");
      chk({16'h0000, oscFrequency}, {16'h0000, s ? cf[3] : cf[1]}, "keyed freq");
      apb(1'b0, fsk_pkg::IDX_STATUS, 32'h0000_0000);
      chk(rd, {a, 13'h0000, s, 2'b11}, "status");
      if (i < 4)
        apb(1'b1, fsk_pkg::IDX_NEXT_SYMBOL, 32'(pat[i+1]));
    end
    apb(1'b1, fsk_pkg::IDX_TIMER_CTRL, 32'h0000_0000);
    $display("test keyed sequence done");
  endtask

  initial
  begin
    num_errors = 0;
    cmp_count  = 0;
    reset_n    = 1'b0;
    ce         = 1'b1;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = '0;
    pwdata     = 32'h0000_0000;
    cf         = '{16'h1234, 16'h5A00, 16'h2345, 16'h3C00, 16'h4CCD, 16'h6000};
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_enable();
    t_seq();
    finish_test();
  end
endmodule
